// ==== logic/mprf_pkg.sv ====
// Constants and types shared by the five-port register file.
// Assumes a single pclk domain with asynchronous active-low reset.
package mprf_pkg;
    localparam int unsigned DW = 8;
    localparam int unsigned AW = 3;
    localparam int unsigned WORDS = 8;
    localparam int unsigned NPORT = 5;
    localparam int unsigned NWR = 3;
    localparam int unsigned NRD = 4;
    // Port slots: A bidirectional, B/C write-only, D/E read-only
    localparam int unsigned P_A = 0;
    localparam int unsigned P_B = 1;
    localparam int unsigned P_C = 2;
    localparam int unsigned P_D = 3;
    localparam int unsigned P_E = 4;
    // Read slots of the store
    localparam int unsigned R_A = 0;
    localparam int unsigned R_D = 1;
    localparam int unsigned R_E = 2;
    localparam int unsigned R_BUS = 3;
    // Register bus map, byte addresses
    localparam int unsigned PAW = 12;
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_STAT = 12'h004;
    localparam logic [11:0] OFF_WORD = 12'h020;
    localparam logic [11:0] OFF_WORD_END = 12'h03c;
    localparam int unsigned CTRL_FREEZE_BIT = 0;
    localparam logic CTRL_FREEZE_RST = 1'b0;
    localparam logic [7:0] CNT_RST = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [AW-1:0] ADDR_RST = 3'h0;
    localparam logic [DW-1:0] DATA_RST = 8'h00;
    typedef enum logic [1:0] {DEC_CTRL, DEC_STAT, DEC_WORD, DEC_BAD} mprf_dec_t;
    typedef enum logic [1:0] {AP_IDLE, AP_FETCH, AP_ANSWER} mprf_apb_t;
endpackage

// ==== logic/mprf_store_if.sv ====
// Carrier between the port logic and the storage array.
// Assumes both ends share pclk.
`timescale 1ns/1ns
`default_nettype none
interface mprf_store_if;
    logic [mprf_pkg::NWR-1:0] wr_en;
    logic [mprf_pkg::NWR-1:0][mprf_pkg::AW-1:0] wr_addr;
    logic [mprf_pkg::NWR-1:0][mprf_pkg::DW-1:0] wr_data;
    logic [mprf_pkg::NRD-1:0][mprf_pkg::AW-1:0] rd_addr;
    logic [mprf_pkg::NRD-1:0][mprf_pkg::DW-1:0] rd_data;
    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// ==== logic/mprf_store.sv ====
// Eight by eight storage with prioritised writes and registered reads.
// Assumes write slot 0 has top priority, then 1, then 2.
`timescale 1ns/1ns
`default_nettype none
module mprf_store (
    input wire logic pclk,
    input wire logic presetn,
    mprf_store_if.store sif
);
    logic [mprf_pkg::DW-1:0] mem_q [mprf_pkg::WORDS];

    // Lowest slot written last so it wins
    always_ff @(posedge pclk) begin
        for (int i = mprf_pkg::NWR - 1; i >= 0; i--) begin
            if (sif.wr_en[i]) begin
                mem_q[sif.wr_addr[i]] <= sif.wr_data[i];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < mprf_pkg::NRD; g++) begin : g_rd
            logic [mprf_pkg::DW-1:0] rd_q;
            // Old contents seen when a write lands on the same edge
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    rd_q <= mprf_pkg::DATA_RST;
                end else begin
                    rd_q <= mem_q[sif.rd_addr[g]];
                end
            end
            assign sif.rd_data[g] = rd_q;
        end
    endgenerate
endmodule // mprf_store
`default_nettype wire

// ==== logic/mprf_port_stage.sv ====
// Rising-edge capture of one port's address and controls.
// Assumes controls are synchronous to pclk.
`timescale 1ns/1ns
`default_nettype none
module mprf_port_stage (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [mprf_pkg::AW-1:0] addr,
    input wire logic en_n,
    input wire logic rd_wr,
    output logic [mprf_pkg::AW-1:0] addr_q,
    output logic en_n_q,
    output logic rd_wr_q,
    output logic drive_q,
    output logic write_q
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_q <= mprf_pkg::ADDR_RST;
            en_n_q <= 1'b1;
            rd_wr_q <= 1'b1;
            drive_q <= 1'b0;
            write_q <= 1'b0;
        end else begin
            addr_q <= addr;
            en_n_q <= en_n;
            rd_wr_q <= rd_wr;
            drive_q <= !en_n && rd_wr;
            write_q <= !en_n && !rd_wr;
        end
    end
endmodule // mprf_port_stage
`default_nettype wire

// ==== logic/mprf_top.sv ====
// Five-port eight-word register file with an APB side window.
// Assumes port pins and APB are synchronous to pclk.
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module mprf_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [mprf_pkg::AW-1:0] a_addr,
    input wire logic a_en_n,
    input wire logic a_rd_wr,
    input wire logic [mprf_pkg::DW-1:0] a_data_in,
    output logic [mprf_pkg::DW-1:0] a_data_out,
    output logic a_data_oe,
    input wire logic [mprf_pkg::AW-1:0] b_addr,
    input wire logic b_en_n,
    input wire logic [mprf_pkg::DW-1:0] b_data,
    input wire logic [mprf_pkg::AW-1:0] c_addr,
    input wire logic c_en_n,
    input wire logic [mprf_pkg::DW-1:0] c_data,
    input wire logic [mprf_pkg::AW-1:0] d_addr,
    input wire logic d_en_n,
    output logic [mprf_pkg::DW-1:0] d_data_out,
    output logic d_data_oe,
    input wire logic [mprf_pkg::AW-1:0] e_addr,
    input wire logic e_en_n,
    output logic [mprf_pkg::DW-1:0] e_data_out,
    output logic e_data_oe,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [mprf_pkg::PAW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    mprf_store_if sif ();

    logic [mprf_pkg::NPORT-1:0][mprf_pkg::AW-1:0] pin_addr;
    logic [mprf_pkg::NPORT-1:0] pin_en_n;
    logic [mprf_pkg::NPORT-1:0] pin_rd_wr;
    logic [mprf_pkg::NPORT-1:0][mprf_pkg::AW-1:0] cap_addr;
    logic [mprf_pkg::NPORT-1:0] cap_drive;
    logic [mprf_pkg::NPORT-1:0] cap_write;
    logic freeze_q;
    logic [7:0] clash_cnt_q;
    logic clash;
    mprf_pkg::mprf_apb_t ap_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    function automatic mprf_pkg::mprf_dec_t dec_addr(input logic [mprf_pkg::PAW-1:0] a);
        mprf_pkg::mprf_dec_t r;
        r = mprf_pkg::DEC_BAD;
        if (a == mprf_pkg::OFF_CTRL) begin
            r = mprf_pkg::DEC_CTRL;
        end else if (a == mprf_pkg::OFF_STAT) begin
            r = mprf_pkg::DEC_STAT;
        end else if (a >= mprf_pkg::OFF_WORD && a <= mprf_pkg::OFF_WORD_END && a[1:0] == 2'b00) begin
            r = mprf_pkg::DEC_WORD;
        end
        return r;
    endfunction

    function automatic logic same_word(input logic en_i, input logic en_j,
                                       input logic [mprf_pkg::AW-1:0] ai, input logic [mprf_pkg::AW-1:0] aj);
        return en_i && en_j && (ai == aj);
    endfunction

    // Pin grouping; B/C fixed to write, D/E fixed to read
    assign pin_addr[mprf_pkg::P_A] = a_addr;
    assign pin_addr[mprf_pkg::P_B] = b_addr;
    assign pin_addr[mprf_pkg::P_C] = c_addr;
    assign pin_addr[mprf_pkg::P_D] = d_addr;
    assign pin_addr[mprf_pkg::P_E] = e_addr;
    assign pin_en_n = {e_en_n, d_en_n, c_en_n, b_en_n, a_en_n};
    assign pin_rd_wr = {1'b1, 1'b1, 1'b0, 1'b0, a_rd_wr};

    genvar g;
    generate
        for (g = 0; g < mprf_pkg::NPORT; g++) begin : g_port
            mprf_port_stage u_stage (
                .pclk(pclk),
                .presetn(presetn),
                .addr(pin_addr[g]),
                .en_n(pin_en_n[g]),
                .rd_wr(pin_rd_wr[g]),
                .addr_q(cap_addr[g]),
                .en_n_q(),
                .rd_wr_q(),
                .drive_q(cap_drive[g]),
                .write_q(cap_write[g])
            );
        end
    endgenerate

    // Writes commit one edge after capture, data taken from pins now
    always_comb begin
        sif.wr_en[mprf_pkg::P_A] = cap_write[mprf_pkg::P_A] && !freeze_q;
        sif.wr_en[mprf_pkg::P_B] = cap_write[mprf_pkg::P_B] && !freeze_q;
        sif.wr_en[mprf_pkg::P_C] = cap_write[mprf_pkg::P_C] && !freeze_q;
        sif.wr_addr[mprf_pkg::P_A] = cap_addr[mprf_pkg::P_A];
        sif.wr_addr[mprf_pkg::P_B] = cap_addr[mprf_pkg::P_B];
        sif.wr_addr[mprf_pkg::P_C] = cap_addr[mprf_pkg::P_C];
        sif.wr_data[mprf_pkg::P_A] = a_data_in;
        sif.wr_data[mprf_pkg::P_B] = b_data;
        sif.wr_data[mprf_pkg::P_C] = c_data;
    end

    // Read address straight from pins so data is ready the next period
    always_comb begin
        sif.rd_addr[mprf_pkg::R_A] = a_addr;
        sif.rd_addr[mprf_pkg::R_D] = d_addr;
        sif.rd_addr[mprf_pkg::R_E] = e_addr;
        sif.rd_addr[mprf_pkg::R_BUS] = paddr[4:2];
    end

    mprf_store u_store (
        .pclk(pclk),
        .presetn(presetn),
        .sif(sif)
    );

    assign a_data_out = sif.rd_data[mprf_pkg::R_A];
    assign d_data_out = sif.rd_data[mprf_pkg::R_D];
    assign e_data_out = sif.rd_data[mprf_pkg::R_E];
    assign a_data_oe = cap_drive[mprf_pkg::P_A];
    assign d_data_oe = cap_drive[mprf_pkg::P_D];
    assign e_data_oe = cap_drive[mprf_pkg::P_E];

    // Two or more enabled writes aimed at one word
    assign clash = same_word(sif.wr_en[0], sif.wr_en[1], sif.wr_addr[0], sif.wr_addr[1])
                || same_word(sif.wr_en[0], sif.wr_en[2], sif.wr_addr[0], sif.wr_addr[2])
                || same_word(sif.wr_en[1], sif.wr_en[2], sif.wr_addr[1], sif.wr_addr[2]);

    // APB sequencing: fetch during first access cycle, answer in second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ap_q <= mprf_pkg::AP_IDLE;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            case (ap_q)
                mprf_pkg::AP_IDLE: begin
                    pready_q <= 1'b0;
                    pslverr_q <= 1'b0;
                    if (psel && !penable) begin
                        ap_q <= mprf_pkg::AP_FETCH;
                    end
                end
                mprf_pkg::AP_FETCH: begin
                    ap_q <= mprf_pkg::AP_ANSWER;
                    pready_q <= 1'b1;
                    prdata_q <= 32'h0000_0000;
                    pslverr_q <= 1'b0;
                    case (dec_addr(paddr))
                        mprf_pkg::DEC_CTRL: begin
                            if (!pwrite) begin
                                prdata_q[mprf_pkg::CTRL_FREEZE_BIT] <= freeze_q;
                            end
                        end
                        mprf_pkg::DEC_STAT: begin
                            if (!pwrite) begin
                                prdata_q[7:0] <= clash_cnt_q;
                            end
                        end
                        mprf_pkg::DEC_WORD: begin
                            if (pwrite) begin
                                pslverr_q <= 1'b1;
                            end else begin
                                prdata_q[mprf_pkg::DW-1:0] <= sif.rd_data[mprf_pkg::R_BUS];
                            end
                        end
                        default: begin
                            pslverr_q <= 1'b1;
                        end
                    endcase
                end
                mprf_pkg::AP_ANSWER: begin
                    ap_q <= mprf_pkg::AP_IDLE;
                    pready_q <= 1'b0;
                    pslverr_q <= 1'b0;
                end
                default: begin
                    ap_q <= mprf_pkg::AP_IDLE;
                    pready_q <= 1'b0;
                end
            endcase
        end
    end

    // Control register, written at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freeze_q <= mprf_pkg::CTRL_FREEZE_RST;
        end else if (ap_q == mprf_pkg::AP_ANSWER && psel && penable && pwrite
                     && dec_addr(paddr) == mprf_pkg::DEC_CTRL) begin
            freeze_q <= pwdata[mprf_pkg::CTRL_FREEZE_BIT];
        end
    end

    // Saturating clash count; a new clash beats a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clash_cnt_q <= mprf_pkg::CNT_RST;
        end else if (ap_q == mprf_pkg::AP_ANSWER && psel && penable && pwrite
                     && dec_addr(paddr) == mprf_pkg::DEC_STAT) begin
            clash_cnt_q <= clash ? 8'h01 : mprf_pkg::CNT_RST;
        end else if (clash && clash_cnt_q != mprf_pkg::CNT_MAX) begin
            clash_cnt_q <= clash_cnt_q + 8'h01;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
endmodule // mprf_top
`default_nettype wire

// ==== sim/mprf_chk.sv ====
// Port checker for the five-port register file.
// Assumes it is bound to mprf_top in the single pclk domain.
`timescale 1ns/1ns
`default_nettype none
module mprf_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] a_addr,
    input wire logic a_en_n,
    input wire logic a_rd_wr,
    input wire logic [7:0] a_data_out,
    input wire logic a_data_oe,
    input wire logic [2:0] d_addr,
    input wire logic d_en_n,
    input wire logic [7:0] d_data_out,
    input wire logic d_data_oe,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    d_drive_a: assert property ($past(presetn) |-> d_data_oe == !$past(d_en_n))
        else $error("d enable mismatch");
    a_drive_a: assert property ($past(presetn) |-> a_data_oe == ($past(a_rd_wr) && !$past(a_en_n)))
        else $error("a enable mismatch");
    a_equals_d_a: assert property (a_data_oe && d_data_oe && $past(a_addr) == $past(d_addr)
        |-> a_data_out == d_data_out) else $error("a and d differ");
    apb_wait_a: assert property (psel && !penable |=> !pready ##1 pready) else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
    ready_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
    err_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
    err_data_a: assert property (pready && pslverr |-> prdata == 32'h0) else $error("error data");
endmodule // mprf_chk
bind mprf_top mprf_chk i_chk (.pclk, .presetn, .a_addr, .a_en_n, .a_rd_wr, .a_data_out, .a_data_oe,
    .d_addr, .d_en_n, .d_data_out, .d_data_oe, .psel, .penable, .prdata, .pready, .pslverr);
`default_nettype wire

// ==== sim/mprf_peer.sv ====
// Datapath side of port A: drives write data and resolves the shared wire.
// Assumes drv_en and drv_val change just after pclk edges.
`timescale 1ns/1ns
`default_nettype none
module mprf_peer (
    input wire logic pclk,
    input wire logic [7:0] a_data_out,
    input wire logic a_data_oe,
    input wire logic drv_en,
    input wire logic [7:0] drv_val,
    output logic [7:0] a_wire
);
    logic [7:0] last_q;
    always_ff @(posedge pclk) begin
        last_q <= a_wire;
    end
    // Released wire never shows a stale value
    always_comb begin
        if (a_data_oe && drv_en) begin
            a_wire = 8'hxx;
        end else if (a_data_oe) begin
            a_wire = a_data_out;
        end else if (drv_en) begin
            a_wire = drv_val;
        end else begin
            a_wire = ~last_q;
        end
    end
endmodule // mprf_peer
`default_nettype wire

// ==== sim/mprf_top_test.sv ====
// Self-checking bench for the five-port register file.
// Assumes mprf_top, mprf_peer and the bound checker are compiled.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("mismatch at %0t got %h expected %h", $time, (g), (e)); end end
module mprf_top_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [2:0] a_addr = '0, b_addr = '0, c_addr = '0, d_addr = '0, e_addr = '0;
    logic a_en_n = 1'b1, a_rd_wr = 1'b1, b_en_n = 1'b1, c_en_n = 1'b1, d_en_n = 1'b1, e_en_n = 1'b1;
    logic drv_en = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err_v;
    logic [7:0] b_data = '0, c_data = '0, drv_val = '0, a_wire, a_data_out, d_data_out, e_data_out;
    logic a_data_oe, d_data_oe, e_data_oe, pready, pslverr;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd_v;
    logic [7:0] exp_mem [8];
    int fails = 0, num_checks = 0, cycles = 0;
    always #50 pclk = ~pclk;
    mprf_top i_dut (.pclk, .presetn, .a_addr, .a_en_n, .a_rd_wr, .a_data_in(a_wire), .a_data_out,
        .a_data_oe, .b_addr, .b_en_n, .b_data, .c_addr, .c_en_n, .c_data, .d_addr, .d_en_n, .d_data_out,
        .d_data_oe, .e_addr, .e_en_n, .e_data_out, .e_data_oe, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr);
    mprf_peer i_peer (.pclk, .a_data_out, .a_data_oe, .drv_en, .drv_val, .a_wire);
    function automatic logic [11:0] wa(input int w);
        return mprf_pkg::OFF_WORD + 12'(4 * w);
    endfunction
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            fails++;
        end
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] ed, input logic ee);
        apb(1'b0, a, 32'h0);
        `CHK(rd_v, ed)
        `CHK(err_v, ee)
    endtask
    task automatic t_fill;
        for (int i = 0; i <= 4; i++) begin
            @(posedge pclk);
            b_addr <= 3'(i);
            c_addr <= 3'(i + 4);
            b_en_n <= (i == 4);
            c_en_n <= (i == 4);
            b_data <= 8'h3a + 8'(i);
            c_data <= 8'hc5 - 8'(i);
            if (i > 0) begin
                exp_mem[i - 1] = 8'h3a + 8'(i);
                exp_mem[i + 3] = 8'hc5 - 8'(i);
            end
        end
        for (int w = 0; w < 8; w++) begin
            rchk(wa(w), {24'h0, exp_mem[w]}, 1'b0);
        end
        $display("fill test done");
    endtask
    task automatic t_read;
        for (int i = 0; i <= 9; i++) begin
            @(posedge pclk);
            d_addr <= 3'(i);
            e_addr <= 3'(7 - i);
            d_en_n <= (i >= 8);
            e_en_n <= (i >= 8);
            @(negedge pclk);
            if (i > 0 && i < 9) begin
                `CHK(d_data_out, exp_mem[i - 1])
                `CHK(e_data_out, exp_mem[8 - i])
                `CHK(e_data_oe, 1'b1)
            end
        end
        `CHK({d_data_oe, e_data_oe}, 2'b00)
        $display("read test done");
    endtask
    task automatic t_rmw;
        @(posedge pclk);
        b_addr <= 3'h2;
        b_en_n <= 1'b0;
        @(posedge pclk);
        b_en_n <= 1'b1;
        b_data <= 8'h99;
        d_addr <= 3'h2;
        e_addr <= 3'h2;
        d_en_n <= 1'b0;
        e_en_n <= 1'b0;
        @(posedge pclk);
        @(negedge pclk);
        `CHK(d_data_out, exp_mem[2])
        @(posedge pclk);
        d_en_n <= 1'b1;
        e_en_n <= 1'b1;
        @(negedge pclk);
        `CHK(e_data_out, 8'h99)
        exp_mem[2] = 8'h99;
        $display("read during write test done");
    endtask
    task automatic t_aport;
        @(posedge pclk);
        a_addr <= 3'h5;
        a_rd_wr <= 1'b0;
        a_en_n <= 1'b0;
        @(posedge pclk);
        a_en_n <= 1'b1;
        drv_en <= 1'b1;
        drv_val <= 8'h6e;
        @(negedge pclk);
        `CHK(a_data_oe, 1'b0)
        @(posedge pclk);
        drv_en <= 1'b0;
        a_rd_wr <= 1'b1;
        a_en_n <= 1'b0;
        d_addr <= 3'h5;
        d_en_n <= 1'b0;
        @(posedge pclk);
        a_en_n <= 1'b1;
        d_en_n <= 1'b1;
        @(negedge pclk);
        `CHK(a_wire, 8'h6e)
        `CHK(a_data_oe, 1'b1)
        @(posedge pclk);
        @(negedge pclk);
        `CHK(a_data_oe, 1'b0)
        exp_mem[5] = 8'h6e;
        $display("port a test done");
    endtask
    task automatic t_clash;
        apb(1'b1, mprf_pkg::OFF_STAT, 32'h0);
        @(posedge pclk);
        a_addr <= 3'h6;
        a_rd_wr <= 1'b0;
        a_en_n <= 1'b0;
        b_addr <= 3'h6;
        b_en_n <= 1'b0;
        c_addr <= 3'h6;
        c_en_n <= 1'b0;
        @(posedge pclk);
        a_en_n <= 1'b1;
        drv_en <= 1'b1;
        drv_val <= 8'h11;
        b_data <= 8'h22;
        c_data <= 8'h33;
        b_addr <= 3'h7;
        c_addr <= 3'h7;
        @(posedge pclk);
        drv_en <= 1'b0;
        b_data <= 8'h44;
        c_data <= 8'h55;
        b_en_n <= 1'b1;
        c_en_n <= 1'b1;
        exp_mem[6] = 8'h11;
        exp_mem[7] = 8'h44;
        rchk(wa(6), 32'h11, 1'b0);
        rchk(wa(7), 32'h44, 1'b0);
        rchk(mprf_pkg::OFF_STAT, 32'h2, 1'b0);
        $display("clash test done");
    endtask
    task automatic t_freeze;
        apb(1'b1, mprf_pkg::OFF_CTRL, 32'h1);
        rchk(mprf_pkg::OFF_CTRL, 32'h1, 1'b0);
        @(posedge pclk);
        b_addr <= 3'h0;
        b_en_n <= 1'b0;
        @(posedge pclk);
        b_en_n <= 1'b1;
        b_data <= 8'hee;
        rchk(wa(0), {24'h0, exp_mem[0]}, 1'b0);
        apb(1'b1, mprf_pkg::OFF_CTRL, 32'h0);
        rchk(12'h100, 32'h0, 1'b1);
        apb(1'b1, wa(1), 32'h5);
        `CHK(err_v, 1'b1)
        rchk(wa(1), {24'h0, exp_mem[1]}, 1'b0);
        $display("freeze and bus error test done");
    endtask
    task automatic t_reset;
        @(negedge pclk);
        `CHK({a_data_oe, d_data_oe, e_data_oe}, 3'b000)
        rchk(mprf_pkg::OFF_CTRL, 32'h0, 1'b0);
        $display("reset test done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_fill();
        t_read();
        t_rmw();
        t_aport();
        t_clash();
        t_freeze();
        report_and_stop();
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            report_and_stop();
        end
    end
endmodule // mprf_top_test
`default_nettype wire
